/* File: vtr_pkg.sv */
// Package of command codes, field layouts and state types for the target and trim registers.
package vtr_pkg;

    // ========================================================================
    // Command codes of the byte registers
    // ========================================================================
    localparam logic [7:0] CMD_IIN_TRIM     = 8'hA5;
    localparam logic [7:0] CMD_VOUT_TARGET  = 8'hA6;
    localparam logic [7:0] CMD_VOUT_READBK  = 8'hA7;

    // ========================================================================
    // Field layouts and codes
    // ========================================================================
    localparam int         TRIM_OFS_LSB     = 0;
    localparam int         TRIM_OFS_MSB     = 3;
    localparam logic [3:0] TRIM_OFS_ZERO    = 4'h8;
    localparam logic [1:0] SRC_SEL_HOST     = 2'h2;
    localparam logic [1:0] STEP_SEL_5MV_A   = 2'h1;
    localparam logic [1:0] STEP_SEL_5MV_B   = 2'h2;
    localparam logic [4:0] STEP_MV_FINE     = 5'h05;
    localparam logic [4:0] STEP_MV_COARSE   = 5'h0A;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    // ========================================================================
    // Slew divider: the host path ramps at one quarter of the fast rate
    // ========================================================================
    localparam int         SLEW_QUARTER_DIV = 4;
    localparam logic [1:0] SLEW_DIV_LAST    = 2'(SLEW_QUARTER_DIV - 1);
    localparam logic [1:0] SLEW_DIV_RESET   = 2'h0;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [0:0] {
        RAMP_IDLE,
        RAMP_MOVE
    } vtr_ramp_t;

    // Byte write or read request from the serial target front end.
    typedef struct packed {
        logic       valid;
        logic [7:0] cmd;
        logic [7:0] data;
    } vtr_req_t;

    // One-cycle answer to a request.
    typedef struct packed {
        logic       valid;
        logic       nack;
        logic [7:0] data;
    } vtr_rsp_t;

endpackage : vtr_pkg

/* File: vtr_regs.sv */
// Output-voltage target, last-commanded readback and input-current offset trim logic.
//
// How it works
// [RULE1] A four-bit offset trim sits in bits 3:0 of the trim register and moves the current report by -2.0 A to +1.75 A in quarter-amp steps.
// [RULE2] The sum of converter result and trim is never clamped, so a negative sum wraps down from the full-scale value.
// [RULE3] Trim codes 0 to 7 subtract current and code 8 leaves the report unchanged.
// [RULE4] Software should choose a trim that keeps the sum non-negative at minimum current so the report never wraps.
// [RULE5] The output follows the host target register only while the source select equals 10b.
// [RULE6] Changes caused by the host target ramp at one quarter of the fast slew rate.
// [RULE7] One target step means 5 mV or 10 mV depending on the step-size select.
// [RULE8] A target write during soft-start or soft-stop is answered with a not-acknowledge.
// [RULE9] After soft-start, target writes are acknowledged even while the output is still moving.
// [RULE10] A new target takes over the ramp at once without waiting for the previous move to end.
// [RULE11] The target is an eight-bit read/write byte, loaded from nonvolatile memory after reset.
// [RULE12] A read-only byte holds the last commanded level from host, voltage-ID bus or boot value, and refuses writes.
// [RULE13] No offset of either bus is added into the last-commanded readback.
// [RULE14] The host readback is the same register that the voltage-ID bus reads at its address 31h.
// [RULE15] Step-size codes 01b and 10b give 5 mV and codes 00b and 11b give 10 mV.
// [RULE16] A refused target write leaves the stored target unchanged.
`timescale 1ns/1ns

module vtr_regs #(
    parameter int IIN_W          = 12,
    parameter int IIN_QUARTER_A  = 4,
    parameter int IIN_FULL_SCALE = 512
) (
    // Clock and reset.
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // Nonvolatile load after reset.
    input  wire logic               nvm_load,
    input  wire logic [7:0]         nvm_vout_target,
    input  wire logic [7:0]         nvm_iin_trim,
    input  wire logic [7:0]         nvm_boot_vid,
    // Byte request and answer toward the serial target front end.
    input  wire vtr_pkg::vtr_req_t  wr_req,
    output      vtr_pkg::vtr_rsp_t  wr_rsp,
    input  wire vtr_pkg::vtr_req_t  rd_req,
    output      vtr_pkg::vtr_rsp_t  rd_rsp,
    // Configuration from other registers of the device.
    input  wire logic [1:0]         voltage_source_select,
    input  wire logic [1:0]         step_size_select,
    input  wire logic               fast_slew_tick,
    input  wire logic               soft_transition_busy,
    // Voltage-ID bus commands.
    input  wire logic               vid_cmd_valid,
    input  wire logic [7:0]         vid_cmd_value,
    // Converter and regulator side.
    input  wire logic [IIN_W-1:0]   iin_adc_result,
    output      logic [IIN_W-1:0]   input_current_reading,
    output      logic [7:0]         vout_setpoint,
    output      logic [4:0]         vout_step_mv,
    output      logic               vout_ramping,
    output      logic [7:0]         vid_bus_readback
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [7:0]          target;
        logic [7:0]          trim;
        logic [7:0]          readback;
        logic [7:0]          vid_target;
        logic [7:0]          setpoint;
        logic [1:0]          slew_div;
        vtr_pkg::vtr_ramp_t  ramp;
        logic [IIN_W-1:0]    iin_rep;
        vtr_pkg::vtr_rsp_t   wr_rsp;
        vtr_pkg::vtr_rsp_t   rd_rsp;
    } vtr_state_t;

    vtr_state_t state_q;
    vtr_state_t state_d;

    // Step size decode; used for the output step, which a check below tests.
    function automatic logic [4:0] vtr_step_mv(input logic [1:0] sel);
        logic fine;
        fine = (sel == vtr_pkg::STEP_SEL_5MV_A) || (sel == vtr_pkg::STEP_SEL_5MV_B);
        return fine ? vtr_pkg::STEP_MV_FINE : vtr_pkg::STEP_MV_COARSE;
    endfunction : vtr_step_mv

    // ========================================================================
    // Input current arithmetic
    // ========================================================================
    localparam int SUM_W = IIN_W + 2;
    localparam logic [SUM_W-1:0] OFS_BIAS = SUM_W'(int'(vtr_pkg::TRIM_OFS_ZERO) * IIN_QUARTER_A);
    localparam logic [SUM_W-1:0] OFS_STEP = SUM_W'(IIN_QUARTER_A);
    localparam logic [SUM_W-1:0] FULL_SC  = SUM_W'(IIN_FULL_SCALE);

    logic [3:0]       trim_code;
    logic [SUM_W-1:0] iin_sum;
    logic [SUM_W-1:0] iin_wrapped;

    // Offset is (code - 8) quarter amps; modular arithmetic keeps the sign in the top bit.
    assign trim_code   = state_q.trim[vtr_pkg::TRIM_OFS_MSB:vtr_pkg::TRIM_OFS_LSB]; // [RULE1]
    assign iin_sum     = {2'b00, iin_adc_result} + SUM_W'(trim_code) * OFS_STEP
                         - OFS_BIAS; // [RULE3]
    // No clamp at zero: a negative sum folds down from full scale.
    assign iin_wrapped = iin_sum[SUM_W-1] ? (iin_sum + FULL_SC) : iin_sum; // [RULE2]

    // ========================================================================
    // Next-state logic
    // ========================================================================
    logic       host_sel;
    logic       tgt_wr;
    logic       tgt_ok;
    logic [7:0] active_tgt;
    logic       step_en;

    // Slow ramping is traded for a single shared step engine for both sources.
    always_comb
    begin
        state_d           = state_q;
        host_sel          = (voltage_source_select == vtr_pkg::SRC_SEL_HOST);
        tgt_wr            = wr_req.valid && (wr_req.cmd == vtr_pkg::CMD_VOUT_TARGET);
        tgt_ok            = tgt_wr && !soft_transition_busy; // [RULE8] [RULE9]
        state_d.wr_rsp    = '0;
        state_d.rd_rsp    = '0;
        state_d.iin_rep   = iin_wrapped[IIN_W-1:0];
        step_en           = 1'b0;

        // Byte writes.
        if (wr_req.valid)
        begin
            state_d.wr_rsp.valid = 1'b1;
            unique case (wr_req.cmd)
                vtr_pkg::CMD_IIN_TRIM:
                begin
                    state_d.trim = wr_req.data;
                end
                vtr_pkg::CMD_VOUT_TARGET:
                begin
                    // Refused writes keep the old target.
                    if (tgt_ok)
                    begin
                        state_d.target = wr_req.data; // [RULE16]
                    end
                    state_d.wr_rsp.nack = !tgt_ok; // [RULE8]
                end
                default:
                begin
                    // The readback byte and unmapped codes do not take writes.
                    state_d.wr_rsp.nack = 1'b1; // [RULE12]
                end
            endcase
        end

        // Byte reads.
        if (rd_req.valid)
        begin
            state_d.rd_rsp.valid = 1'b1;
            unique case (rd_req.cmd)
                vtr_pkg::CMD_IIN_TRIM:    state_d.rd_rsp.data = state_q.trim;
                vtr_pkg::CMD_VOUT_TARGET: state_d.rd_rsp.data = state_q.target; // [RULE11]
                vtr_pkg::CMD_VOUT_READBK: state_d.rd_rsp.data = state_q.readback; // [RULE12]
                default:
                begin
                    state_d.rd_rsp.data = vtr_pkg::READ_UNMAPPED;
                    state_d.rd_rsp.nack = 1'b1;
                end
            endcase
        end

        // Last commanded level: raw codes only, offsets never enter here.
        if (tgt_ok && host_sel)
        begin
            state_d.readback = wr_req.data; // [RULE12] [RULE13]
        end
        if (vid_cmd_valid)
        begin
            state_d.vid_target = vid_cmd_value;
            if (!host_sel)
            begin
                state_d.readback = vid_cmd_value; // [RULE12] [RULE13]
            end
        end

        // Quarter-rate divider for the host path.
        if (fast_slew_tick)
        begin
            if (state_q.slew_div == vtr_pkg::SLEW_DIV_LAST)
            begin
                state_d.slew_div = vtr_pkg::SLEW_DIV_RESET;
            end
            else
            begin
                state_d.slew_div = state_q.slew_div + 2'h1;
            end
        end
        step_en = host_sel
                ? (fast_slew_tick && (state_q.slew_div == vtr_pkg::SLEW_DIV_LAST)) // [RULE6]
                : fast_slew_tick;

        // The ramp always chases the present target, so a new one redirects it at once.
        active_tgt = host_sel ? state_q.target : state_q.vid_target; // [RULE5] [RULE10]
        unique case (state_q.ramp)
            vtr_pkg::RAMP_IDLE:
            begin
                if (state_q.setpoint != active_tgt)
                begin
                    state_d.ramp = vtr_pkg::RAMP_MOVE;
                end
            end
            vtr_pkg::RAMP_MOVE:
            begin
                if (state_q.setpoint == active_tgt)
                begin
                    state_d.ramp = vtr_pkg::RAMP_IDLE;
                end
                else if (step_en)
                begin
                    state_d.setpoint = (state_q.setpoint < active_tgt)
                                     ? state_q.setpoint + 8'h01
                                     : state_q.setpoint - 8'h01; // [RULE10]
                end
            end
        endcase

        // Nonvolatile load has the last word over everything else.
        if (nvm_load)
        begin
            state_d.target     = nvm_vout_target; // [RULE11]
            state_d.trim       = nvm_iin_trim;
            state_d.readback   = nvm_boot_vid; // [RULE12]
            state_d.vid_target = nvm_boot_vid;
            state_d.setpoint   = nvm_boot_vid;
            state_d.slew_div   = vtr_pkg::SLEW_DIV_RESET;
            state_d.ramp       = vtr_pkg::RAMP_IDLE;
        end
    end

    // ========================================================================
    // State register
    // ========================================================================
    // Trim resets to the neutral code so an unloaded part reports raw current.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q      <= '0;
            state_q.trim <= {4'h0, vtr_pkg::TRIM_OFS_ZERO};
            state_q.ramp <= vtr_pkg::RAMP_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign wr_rsp                = state_q.wr_rsp;
    assign rd_rsp                = state_q.rd_rsp;
    assign input_current_reading = state_q.iin_rep;
    assign vout_setpoint         = state_q.setpoint;
    assign vout_step_mv          = vtr_step_mv(step_size_select); // [RULE7] [RULE15]
    assign vout_ramping          = (state_q.ramp == vtr_pkg::RAMP_MOVE);
    // Both buses read one register, so they can never disagree.
    assign vid_bus_readback      = state_q.readback; // [RULE14]

    // ========================================================================
    // Assertions
    // ========================================================================
    sequence s_busy_target_write;
        wr_req.valid && (wr_req.cmd == vtr_pkg::CMD_VOUT_TARGET) && soft_transition_busy
            && !nvm_load;
    endsequence

    sequence s_free_target_write;
        wr_req.valid && (wr_req.cmd == vtr_pkg::CMD_VOUT_TARGET) && !soft_transition_busy
            && !nvm_load;
    endsequence

    AST_BUSY_NACK: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE8]
        s_busy_target_write |=> (wr_rsp.valid && wr_rsp.nack))
        else $error("target write during soft transition not refused");

    AST_BUSY_KEEP: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE16]
        s_busy_target_write |=> $stable(state_q.target))
        else $error("refused target write changed the target");

    AST_FREE_ACK: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE9]
        s_free_target_write |=> (wr_rsp.valid && !wr_rsp.nack
            && state_q.target == $past(wr_req.data)))
        else $error("accepted target write not stored or not acknowledged");

    AST_READBK_NO_WRITE: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE12]
        (wr_req.valid && wr_req.cmd == vtr_pkg::CMD_VOUT_READBK)
            |=> (wr_rsp.valid && wr_rsp.nack))
        else $error("write to readback byte was acknowledged");

    AST_READBK_SYNC: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE14]
        (rd_req.valid && rd_req.cmd == vtr_pkg::CMD_VOUT_READBK)
            |=> (rd_rsp.data == $past(vid_bus_readback)))
        else $error("host readback differs from voltage-ID readback");

    AST_STEP_SIZE: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE15]
        (step_size_select == vtr_pkg::STEP_SEL_5MV_A || step_size_select == vtr_pkg::STEP_SEL_5MV_B)
            == (vout_step_mv == vtr_pkg::STEP_MV_FINE))
        else $error("step size does not follow its select");

    AST_HOST_SOURCE_ONLY: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE5]
        (!host_sel && !nvm_load && $stable(state_q.vid_target) && state_q.setpoint == state_q.vid_target
            && !vid_cmd_valid) |=> $stable(vout_setpoint))
        else $error("output moved while host path not selected");

    AST_QUARTER_RATE: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE6]
        (host_sel && !nvm_load && state_q.slew_div != vtr_pkg::SLEW_DIV_LAST)
            |=> $stable(vout_setpoint))
        else $error("host ramp stepped off the quarter rate");

    AST_ZERO_TRIM: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE3]
        (trim_code == vtr_pkg::TRIM_OFS_ZERO) |=> (input_current_reading == $past(iin_adc_result)))
        else $error("neutral trim changed the current report");

    AST_WRAP: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE2]
        (iin_sum[SUM_W-1]) |=> (input_current_reading == IIN_W'($past(iin_sum) + FULL_SC)
            && input_current_reading != '0))
        else $error("negative current sum was clamped instead of wrapped");

endmodule : vtr_regs

/* File: vtr_host_model.sv */
// Host-side byte master model that issues register writes and reads.
`timescale 1ns/1ns

module vtr_host_model (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // Requests toward the register block.
    output      vtr_pkg::vtr_req_t wr_req,
    output      vtr_pkg::vtr_req_t rd_req,
    // Answers from the register block.
    input  wire vtr_pkg::vtr_rsp_t wr_rsp,
    input  wire vtr_pkg::vtr_rsp_t rd_rsp
);
    // ==============================
    // Idle state
    // ==============================
    // Idle fields carry a pattern, so stale data is never mistaken for live data.
    initial
    begin
        wr_req = '{1'b0, 8'h5A, 8'hC3};
        rd_req = '{1'b0, 8'hA5, 8'h3C};
    end

    // ==============================
    // Single-byte transfer
    // ==============================
    // One byte per transfer, held until the taking edge, then scrambled.
    task automatic xfer(input logic is_rd, input logic [7:0] cmd, input logic [7:0] data,
                        output vtr_pkg::vtr_rsp_t rsp, output logic ok);
        int i;
        ok  = 1'b0;
        rsp = '0;
        @(posedge core_clk);
        if (is_rd)
            rd_req <= '{1'b1, cmd, data};
        else
            wr_req <= '{1'b1, cmd, data};
        @(posedge core_clk);
        if (is_rd)
            rd_req <= '{1'b0, ~cmd, ~data};
        else
            wr_req <= '{1'b0, ~cmd, ~data};
        // The answer stands one cycle, so it is looked at on each of up to four following edges.
        for (i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            rsp = is_rd ? rd_rsp : wr_rsp;
            if (rsp.valid === 1'b1 && resetn === 1'b1)
            begin
                ok = 1'b1;
                break;
            end
        end
    endtask : xfer

endmodule : vtr_host_model

/* File: vtr_regs_tb_top.sv */
// Self-checking testbench of the voltage target and current trim registers.
`timescale 1ns/1ns

`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
        end \
    end

module vtr_regs_tb_top;
    // ==============================
    // Signals
    // ==============================
    logic              core_clk, resetn, nvm_load, fast_slew_tick;
    logic              soft_transition_busy, vid_cmd_valid, vout_ramping;
    logic [7:0]        nvm_vout_target, nvm_iin_trim, nvm_boot_vid, vid_cmd_value;
    logic [7:0]        vout_setpoint, vid_bus_readback;
    logic [1:0]        voltage_source_select, step_size_select;
    logic [11:0]       iin_adc_result, input_current_reading;
    logic [4:0]        vout_step_mv;
    vtr_pkg::vtr_req_t wr_req, rd_req;
    vtr_pkg::vtr_rsp_t wr_rsp, rd_rsp;
    int                n_errors, tests_run, i;
    logic [3:0]        codes [5] = '{4'h0, 4'h7, 4'h8, 4'hF, 4'h0};
    logic [11:0]       adcs  [5] = '{12'h028, 12'h028, 12'h028, 12'h028, 12'h00A};

    vtr_regs vtr_regs_inst (.core_clk, .resetn, .nvm_load, .nvm_vout_target, .nvm_iin_trim,
        .nvm_boot_vid, .wr_req, .wr_rsp, .rd_req, .rd_rsp, .voltage_source_select,
        .step_size_select, .fast_slew_tick, .soft_transition_busy, .vid_cmd_valid,
        .vid_cmd_value, .iin_adc_result, .input_current_reading, .vout_setpoint,
        .vout_step_mv, .vout_ramping, .vid_bus_readback);

    vtr_host_model vtr_host_model_inst (.core_clk, .resetn, .wr_req, .rd_req, .wr_rsp,
        .rd_rsp);

    // Clock at 125 MHz.
    always #4 core_clk = ~core_clk;

    // ==============================
    // Tasks
    // ==============================
    task automatic stop_test();
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // A transfer that never answers counts as a mismatch and ends the run.
    task automatic xfer(input logic r, input logic [7:0] c, input logic [7:0] d,
                        input logic [7:0] exp_d, input logic exp_n);
        vtr_pkg::vtr_rsp_t rsp;
        logic              ok;
        vtr_host_model_inst.xfer(r, c, d, rsp, ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            stop_test();
        end
        `CHK("nack", exp_n, rsp.nack)
        if (r)
            `CHK("read data", exp_d, rsp.data)
        else
            `CHK("write data", 8'h00, rsp.data)
    endtask : xfer

    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic n);
        xfer(1'b0, c, d, 8'h00, n);
    endtask : wr

    task automatic rd(input logic [7:0] c, input logic [7:0] d, input logic n);
        xfer(1'b1, c, 8'h00, d, n);
    endtask : rd

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cycles

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            fast_slew_tick <= 1'b1;
            @(posedge core_clk);
            fast_slew_tick <= 1'b0;
        end
        cycles(1);
    endtask : ticks

    // Offset is a quarter amp per code around code 8, wrapping below zero.
    function automatic logic [11:0] exp_iin(input logic [3:0] c, input logic [11:0] a);
        int v;
        v = int'(a) + (int'(c) - 8) * 4;
        if (v < 0)
            v += 512;
        return 12'(v);
    endfunction : exp_iin

    // ==============================
    // Main sequence
    // ==============================
    initial
    begin
        {core_clk, resetn, nvm_load, fast_slew_tick, soft_transition_busy} = '0;
        {vid_cmd_valid, vid_cmd_value, voltage_source_select, step_size_select} = '0;
        {nvm_vout_target, nvm_iin_trim, nvm_boot_vid, iin_adc_result} = '0;
        n_errors  = 0;
        tests_run = 0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        rd(8'hA5, 8'h08, 1'b0);
        rd(8'hA6, 8'h00, 1'b0);
        rd(8'hA7, 8'h00, 1'b0);
        // Zero offset keeps the current sum non-negative.
        @(posedge core_clk);
        {nvm_load, nvm_vout_target, nvm_iin_trim, nvm_boot_vid} <= {1'b1, 24'h30_58_20};
        @(posedge core_clk);
        nvm_load <= 1'b0;
        rd(8'hA6, 8'h30, 1'b0);
        rd(8'hA5, 8'h58, 1'b0);
        rd(8'hA7, 8'h20, 1'b0);
        `CHK("vid readback", 8'h20, vid_bus_readback)
        wr(8'hA7, 8'h55, 1'b1);
        rd(8'hA7, 8'h20, 1'b0);
        wr(8'hFF, 8'h55, 1'b1);
        rd(8'h00, vtr_pkg::READ_UNMAPPED, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            step_size_select <= 2'(i);
            cycles(1);
            `CHK("step", (i == 1 || i == 2) ? 5'h05 : 5'h0A, vout_step_mv)
        end
        for (i = 0; i < 5; i++)
        begin
            wr(8'hA5, {4'hA, codes[i]}, 1'b0);
            rd(8'hA5, {4'hA, codes[i]}, 1'b0);
            iin_adc_result <= adcs[i];
            cycles(2);
            `CHK("current", exp_iin(codes[i], adcs[i]), input_current_reading)
        end
        @(posedge core_clk);
        soft_transition_busy <= 1'b1;
        wr(8'hA6, 8'h77, 1'b1);
        rd(8'hA6, 8'h30, 1'b0);
        soft_transition_busy <= 1'b0;
        voltage_source_select <= 2'h2;
        wr(8'hA6, 8'h22, 1'b0);
        `CHK("vid readback", 8'h22, vid_bus_readback)
        cycles(1);
        `CHK("ramping", 1'b1, vout_ramping)
        ticks(3);
        `CHK("setpoint", 8'h20, vout_setpoint)
        ticks(1);
        `CHK("setpoint", 8'h21, vout_setpoint)
        wr(8'hA6, 8'h1E, 1'b0);
        ticks(4);
        `CHK("setpoint", 8'h20, vout_setpoint)
        wr(8'hA6, 8'h10, 1'b0);
        ticks(4);
        `CHK("setpoint", 8'h1F, vout_setpoint)
        rd(8'hA7, 8'h10, 1'b0);
        // Leaving the host source must stop the setpoint following the target.
        voltage_source_select <= 2'h0;
        wr(8'hA6, 8'h40, 1'b0);
        ticks(8);
        `CHK("setpoint", 8'h20, vout_setpoint)
        @(posedge core_clk);
        {vid_cmd_valid, vid_cmd_value} <= {1'b1, 8'h18};
        @(posedge core_clk);
        vid_cmd_valid <= 1'b0;
        rd(8'hA7, 8'h18, 1'b0);
        `CHK("vid readback", 8'h18, vid_bus_readback)
        ticks(8);
        `CHK("setpoint", 8'h18, vout_setpoint)
        stop_test();
    end

endmodule : vtr_regs_tb_top
